// *** verilog/dbg_link_params.svh ***
// Purpose: constants for the debug line error and break logic
// Assumes: 100 MHz system clock
// Notes: bit counts are in bit times measured by the auto-baud logic
`ifndef DBG_LINK_PARAMS_SVH
`define DBG_LINK_PARAMS_SVH
`define BREAK_MIN_BITS 8'h09
`define BREAK_TX_BITS 8'h28
`define AUTOBAUD_BYTE 8'h80
`define BREAK_OPCODE 8'h00
`define FRAME_BITS 4'ha
`define BAUD_DEFAULT 16'h0364
`define WP_RD_BIT 0
`define WP_WR_BIT 1
`define WP_DATA_BIT 2
`endif

// *** verilog/dbg_link_pkg.sv ***
// Purpose: types for the debug line error and break logic
// Assumes: nothing
// Notes: link states only
package dbg_link_pkg;
	typedef enum logic [2:0] {
		LK_BAUD,
		LK_IDLE,
		LK_RX,
		LK_TX,
		LK_BRKTX,
		LK_HELD
	} link_state_type;
endpackage

// *** verilog/dbg_fifo.sv ***
// Purpose: byte FIFO between the debug line receiver and the command logic
// Assumes: one clock, valid/ready on both sides
// Notes: flush drops all contents
`timescale 1ns/1ps
`default_nettype none
module dbg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic push;
	logic pop;
	assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
	assign out_valid = wp_r != rp_r;
	assign out_data = mem[rp_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// pointers carry an extra wrap bit for honest full and empty
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (flush) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end
	// storage has no reset
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wp_r[AW-1:0]] <= in_data;
	end
endmodule
`default_nettype wire

// *** verilog/dbg_link.sv ***
// Purpose: debug line error handling, break instruction and watchpoint logic
// Assumes: debug line open drain, idle high; inputs synchronous to clk_sys
// Notes: bit time measured from the 80h autobaud byte, 8N1 framing
// Operation
// [RULE_01] A line held low for nine or more bit times resets the autobaud logic.
// [RULE_02] After a break the host sends 80h and its low time sets the bit time.
// [RULE_03] Break, low stop bit and transmit collision are each flagged as line errors.
// [RULE_04] Any line error aborts the command, sends a four character break and resets autobaud; a host break sends no break.
// [RULE_05] The line is only ever pulled low, never driven high.
// [RULE_06] The host sends a break on connecting and when recovering from an error.
// [RULE_07] A host break resets only autobaud; control bits and debug mode are kept.
// [RULE_08] The link logic stays in reset until the line returns high after a break.
// [RULE_09] A host break is seen even while the device is transmitting; here LK_BRKTX ignores it and LK_TX flags a collision first.
// [RULE_10] The core decoding opcode 00h signals a break indication.
// [RULE_11] With breakpoints enabled a break indication enters debug mode and stalls the core.
// [RULE_12] With breakpoints disabled the indication is ignored and the opcode acts as a no-op.
// [RULE_13] The host places breakpoints by writing 00h and removes them by page erase and reprogram.
// [RULE_14] One watchpoint on one register address breaks on reads, writes or both.
// [RULE_15] With data match on, the watchpoint fires only when the transfer value equals it.
// [RULE_16] An unselected access type or data mismatch gives no break.
// [RULE_17] Collision is a low line sampled mid bit while the device releases the line.
`timescale 1ns/1ps
`default_nettype none
`include "dbg_link_params.svh"
module dbg_link #(
	parameter int BAUD_W = 16,
	parameter int ADDR_W = 12,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// debug line, open drain
	input wire logic dline_in,
	output logic dline_out,
	output logic dline_oe_n,
	// core decode and register file accesses
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic rf_rd,
	input wire logic rf_wr,
	input wire logic [ADDR_W-1:0] rf_addr,
	input wire logic [7:0] rf_data,
	// configuration
	input wire logic bp_enable,
	input wire logic [2:0] wp_ctrl,
	input wire logic [ADDR_W-1:0] wp_addr,
	input wire logic [7:0] wp_data,
	input wire logic debug_exit,
	// transmit request from command logic
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic cmd_ready,
	// status
	output logic debug_mode,
	output logic core_stall,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic tx_ready,
	output logic cmd_abort,
	output logic err_break,
	output logic err_frame,
	output logic err_collide,
	output logic baud_locked
);
	typedef struct packed {
		dbg_link_pkg::link_state_type st;
		logic [BAUD_W-1:0] bit_time;
		logic [BAUD_W-1:0] cnt;
		logic [BAUD_W+3:0] low_cnt;
		logic [3:0] bitn;
		logic [5:0] brk_bits;
		logic [9:0] shreg;
		logic [7:0] rxd;
		logic rx_push;
		logic drive_low;
		logic dbg;
		logic stall;
		logic abort;
		logic e_brk;
		logic e_frm;
		logic e_col;
		logic locked;
		logic txr;
	} state_type;

	state_type s_r;
	state_type s_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;
	logic wp_hit;
	logic brk_ind;
	logic host_break;

	// long low line, nine bit times, seen in any state once the bit time is locked
	assign host_break = s_r.locked && !dline_in &&
		(s_r.low_cnt >= (BAUD_W+4)'(`BREAK_MIN_BITS) * (BAUD_W+4)'(s_r.bit_time)); // [RULE_01] [RULE_09]
	assign brk_ind = opcode_valid && opcode == `BREAK_OPCODE; // [RULE_10]

	// watchpoint compare
	always_comb begin
		wp_hit = (rf_addr == wp_addr) &&
			((rf_rd && wp_ctrl[`WP_RD_BIT]) || (rf_wr && wp_ctrl[`WP_WR_BIT])) && // [RULE_14] [RULE_16]
			(!wp_ctrl[`WP_DATA_BIT] || rf_data == wp_data); // [RULE_15]
	end

	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.rx_push = 1'b0;
		s_nxt.abort = 1'b0;
		s_nxt.e_brk = 1'b0;
		s_nxt.e_frm = 1'b0;
		s_nxt.e_col = 1'b0;
		s_nxt.low_cnt = dline_in ? '0 : s_r.low_cnt + 1'b1;
		s_nxt.cnt = s_r.cnt + 1'b1;
		// debug mode survives any line break
		if ((brk_ind && bp_enable) || wp_hit) begin // [RULE_11] [RULE_07] [RULE_12]
			s_nxt.dbg = 1'b1;
			s_nxt.stall = 1'b1;
		end else if (debug_exit) begin
			s_nxt.dbg = 1'b0;
			s_nxt.stall = 1'b0;
		end
		// breakpoints off: the indication is dropped and the opcode runs as a no-op
		s_nxt.txr = 1'b0;
		case (s_r.st)
		dbg_link_pkg::LK_BAUD: begin
			// 80h: start plus seven zero bits low, measured as 8 bit times
			s_nxt.drive_low = 1'b0;
			if (!dline_in && s_r.low_cnt == '0)
				s_nxt.cnt = '0;
			if (dline_in && s_r.low_cnt != '0 && s_r.low_cnt[BAUD_W+2:0] >= 8) begin // [RULE_02]
				s_nxt.bit_time = s_r.low_cnt[BAUD_W+2:3];
				s_nxt.locked = 1'b1;
				s_nxt.st = dbg_link_pkg::LK_IDLE;
			end
		end
		dbg_link_pkg::LK_IDLE: begin
			// offer a send slot only while the receive queue has room
			s_nxt.txr = fifo_in_ready;
			s_nxt.cnt = '0;
			if (!dline_in) begin
				s_nxt.st = dbg_link_pkg::LK_RX;
				s_nxt.bitn = '0;
				s_nxt.txr = 1'b0;
			end else if (tx_valid) begin
				s_nxt.st = dbg_link_pkg::LK_TX;
				s_nxt.shreg = {1'b1, tx_byte, 1'b0};
				s_nxt.bitn = '0;
				s_nxt.drive_low = 1'b1;
				s_nxt.txr = 1'b0;
			end
		end
		dbg_link_pkg::LK_RX: begin
			// sample mid bit
			if (s_r.cnt == (s_r.bit_time >> 1)) begin
				s_nxt.shreg = {dline_in, s_r.shreg[9:1]};
			end
			if (s_r.cnt >= s_r.bit_time - 1'b1) begin
				s_nxt.cnt = '0;
				s_nxt.bitn = s_r.bitn + 1'b1;
				if (s_r.bitn == `FRAME_BITS - 1'b1) begin
					if (!s_r.shreg[9]) begin
						s_nxt.e_frm = 1'b1; // [RULE_03]
					end else begin
						s_nxt.rxd = s_r.shreg[8:1];
						s_nxt.rx_push = 1'b1;
						s_nxt.st = dbg_link_pkg::LK_HELD;
					end
				end
			end
		end
		dbg_link_pkg::LK_TX: begin
			// released bit read back low means the host is talking too
			if (s_r.cnt == (s_r.bit_time >> 1) && !s_r.drive_low && !dline_in)
				s_nxt.e_col = 1'b1; // [RULE_17] [RULE_03]
			if (s_r.cnt >= s_r.bit_time - 1'b1) begin
				s_nxt.cnt = '0;
				s_nxt.bitn = s_r.bitn + 1'b1;
				s_nxt.shreg = {1'b1, s_r.shreg[9:1]};
				s_nxt.drive_low = !s_r.shreg[1];
				if (s_r.bitn == `FRAME_BITS - 1'b1) begin
					s_nxt.drive_low = 1'b0;
					s_nxt.st = dbg_link_pkg::LK_HELD;
				end
			end
		end
		dbg_link_pkg::LK_BRKTX: begin
			// four characters of low, pull only
			s_nxt.drive_low = 1'b1; // [RULE_05]
			if (s_r.cnt >= s_r.bit_time - 1'b1) begin
				s_nxt.cnt = '0;
				s_nxt.brk_bits = s_r.brk_bits + 1'b1;
				if (s_r.brk_bits == 6'(`BREAK_TX_BITS - 1)) begin // [RULE_04]
					s_nxt.drive_low = 1'b0;
					s_nxt.st = dbg_link_pkg::LK_HELD;
					s_nxt.locked = 1'b0;
					s_nxt.bit_time = BAUD_W'(`BAUD_DEFAULT);
				end
			end
		end
		dbg_link_pkg::LK_HELD: begin
			// wait for line high before leaving reset
			s_nxt.drive_low = 1'b0;
			if (dline_in)
				s_nxt.st = s_r.locked ? dbg_link_pkg::LK_IDLE : dbg_link_pkg::LK_BAUD; // [RULE_08]
		end
		default: s_nxt.st = dbg_link_pkg::LK_BAUD;
		endcase
		// a host break overrides whatever was in progress, except the device's own break in LK_BRKTX
		if (host_break && s_r.st != dbg_link_pkg::LK_BRKTX) begin
			s_nxt.e_brk = 1'b1; // [RULE_03]
			s_nxt.locked = 1'b0; // [RULE_01] [RULE_07]
			s_nxt.bit_time = BAUD_W'(`BAUD_DEFAULT);
			s_nxt.drive_low = 1'b0;
			s_nxt.st = dbg_link_pkg::LK_HELD; // [RULE_08]
		end else if (s_nxt.e_frm || s_nxt.e_col) begin
			s_nxt.st = dbg_link_pkg::LK_BRKTX; // [RULE_04]
			s_nxt.cnt = '0;
			s_nxt.brk_bits = '0;
			s_nxt.drive_low = 1'b1;
		end
		if (s_nxt.e_brk || s_nxt.e_frm || s_nxt.e_col)
			s_nxt.abort = 1'b1; // [RULE_04]
	end

	// state register; bit_time reset to a plain default
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.st <= dbg_link_pkg::LK_HELD;
			s_r.bit_time <= BAUD_W'(`BAUD_DEFAULT);
		end else begin
			s_r <= s_nxt;
		end
	end

	// received bytes queue up for the command logic; a full queue drops
	dbg_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.flush(s_r.abort),
		.in_valid(s_r.rx_push),
		.in_ready(fifo_in_ready),
		.in_data(s_r.rxd),
		.out_valid(fifo_out_valid),
		.out_ready(cmd_ready),
		.out_data(fifo_out_data)
	);

	// outputs from flops
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
		end else begin
			rx_valid <= fifo_out_valid && !cmd_ready;
			rx_byte <= fifo_out_data;
		end
	end
	assign dline_out = 1'b0;
	assign dline_oe_n = !s_r.drive_low; // [RULE_05]
	assign debug_mode = s_r.dbg;
	assign core_stall = s_r.stall;
	assign tx_ready = s_r.txr;
	assign cmd_abort = s_r.abort;
	assign err_break = s_r.e_brk;
	assign err_frame = s_r.e_frm;
	assign err_collide = s_r.e_col;
	assign baud_locked = s_r.locked;

	a_bp_enter: assert property (@(posedge clk_sys) disable iff (!rstn)
		brk_ind && bp_enable |=> debug_mode && core_stall) // [RULE_11]
		else $error("break indication did not enter debug mode");
	a_bp_ignore: assert property (@(posedge clk_sys) disable iff (!rstn)
		!debug_mode && !(brk_ind && bp_enable) && !wp_hit |=> !debug_mode) // [RULE_12]
		else $error("debug mode entered without cause");
	a_wp_fire: assert property (@(posedge clk_sys) disable iff (!rstn)
		wp_hit |=> debug_mode) // [RULE_14]
		else $error("watchpoint hit lost");
	a_wp_data: assert property (@(posedge clk_sys) disable iff (!rstn)
		wp_ctrl[`WP_DATA_BIT] && rf_data != wp_data |-> !wp_hit) // [RULE_15]
		else $error("watchpoint fired on data mismatch");
	a_wp_type: assert property (@(posedge clk_sys) disable iff (!rstn)
		!(rf_rd && wp_ctrl[`WP_RD_BIT]) && !(rf_wr && wp_ctrl[`WP_WR_BIT]) |-> !wp_hit) // [RULE_16]
		else $error("watchpoint fired on unselected access");
	a_err_abort: assert property (@(posedge clk_sys) disable iff (!rstn)
		err_frame || err_collide |-> cmd_abort && !dline_oe_n) // [RULE_04]
		else $error("line error without abort and break");
	a_brk_keep: assert property (@(posedge clk_sys) disable iff (!rstn)
		debug_mode && err_break && !debug_exit |=> debug_mode) // [RULE_07]
		else $error("host break left debug mode");
	a_brk_unlock: assert property (@(posedge clk_sys) disable iff (!rstn)
		host_break && s_r.st != dbg_link_pkg::LK_BRKTX |=> !baud_locked && err_break) // [RULE_01]
		else $error("host break did not reset autobaud");
	a_held_line: assert property (@(posedge clk_sys) disable iff (!rstn)
		s_r.st == dbg_link_pkg::LK_HELD && !dline_in && !host_break |=>
		s_r.st == dbg_link_pkg::LK_HELD) // [RULE_08]
		else $error("left reset while line low");
endmodule
`default_nettype wire

// *** verification/dbg_host.sv ***
// Purpose: host adapter model on the open drain debug line
// Assumes: pull-up on the line, bit time BT clocks after the rate byte
// Notes: tasks are called from the bench; rate and send release the line at the end, hold leaves the level it was given
`timescale 1ns/1ps
`default_nettype none
module dbg_host #(
	parameter int BT = 16
) (
	// clock
	input wire logic clk_sys,
	// line pull, low pulls the wire down
	output logic host_low_n
);
	initial host_low_n = 1'b1;
	// hold a level for n bit times; high means released to the pull-up
	task automatic hold(input logic lvl, input int n);
		host_low_n <= lvl;
		repeat (n * BT) @(posedge clk_sys);
	endtask
	// rate byte: eight low bit times, then released
	task automatic rate();
		hold(1'b0, 8);
		hold(1'b1, 4);
	endtask
	// one 8N1 frame lsb first; a low stop makes a framing fault on purpose
	task automatic send(input logic [7:0] b, input logic stop);
		hold(1'b0, 1);
		for (int i = 0; i < 8; i++) hold(b[i], 1);
		hold(stop, 1);
		hold(1'b1, 2);
	endtask
endmodule
`default_nettype wire

// *** verification/debug_link_error_and_break_logic_tb.sv ***
// Purpose: bench for the debug line error and break logic
// Assumes: rate byte sets a 16 clock bit time
// Notes: one-cycle pulses are caught in sticky flags
`timescale 1ns/1ps
`default_nettype none
module debug_link_error_and_break_logic_tb;
	localparam int BT = 16;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] opcode = 8'h00, rf_data = 8'h00, tx_byte = 8'h00, wp_data = 8'h6e;
	logic opcode_valid = 1'b0, rf_rd = 1'b0, rf_wr = 1'b0, bp_enable = 1'b0;
	logic debug_exit = 1'b0, tx_valid = 1'b0, cmd_ready = 1'b0, clr = 1'b0;
	logic [11:0] rf_addr = 12'h000, wp_addr = 12'h3c5;
	logic [2:0] wp_ctrl = 3'h0;
	logic [3:0] seen = 4'h0;
	logic dline_out, dline_oe_n, debug_mode, core_stall, rx_valid, tx_ready, host_low_n;
	logic cmd_abort, err_break, err_frame, err_collide, baud_locked;
	logic [7:0] rx_byte;
	int n_mismatch = 0, num_checks = 0, cyc = 0, low_cnt = 0, brk_len = 0, k;
	// wired-and of both pullers over the pull-up
	wire logic line = host_low_n & (dline_oe_n | dline_out);
	wire logic [3:0] st = {dline_oe_n, debug_mode, rx_valid, baud_locked};
	dbg_host #(.BT(BT)) host_u (.clk_sys(clk_sys), .host_low_n(host_low_n));
	dbg_link dut_u (.clk_sys(clk_sys), .rstn(rstn), .dline_in(line), .dline_out(dline_out),
		.dline_oe_n(dline_oe_n), .opcode(opcode), .opcode_valid(opcode_valid), .rf_rd(rf_rd),
		.rf_wr(rf_wr), .rf_addr(rf_addr), .rf_data(rf_data), .bp_enable(bp_enable),
		.wp_ctrl(wp_ctrl), .wp_addr(wp_addr), .wp_data(wp_data), .debug_exit(debug_exit),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .cmd_ready(cmd_ready),
		.debug_mode(debug_mode), .core_stall(core_stall), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .tx_ready(tx_ready), .cmd_abort(cmd_abort), .err_break(err_break),
		.err_frame(err_frame), .err_collide(err_collide), .baud_locked(baud_locked));
	always #5 clk_sys = ~clk_sys;
	// sticky pulses, and length of each device pull; pulses last one cycle only
	always @(posedge clk_sys) begin
		seen <= clr ? 4'h0 : seen | {cmd_abort, err_break, err_frame, err_collide};
		low_cnt <= dline_oe_n ? 0 : low_cnt + 1;
		if (dline_oe_n && low_cnt != 0) brk_len <= low_cnt;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// bounded wait, sampled at the falling edge where outputs are settled
	task automatic wait_st(input int i, input logic v);
		for (int j = 0; j < 2000 && st[i] !== v; j++) @(negedge clk_sys);
	endtask
	task automatic pulse_clr();
		ticks(1);
		clr <= 1'b1;
		ticks(1);
		clr <= 1'b0;
	endtask
	task automatic drain(input logic [7:0] exp);
		wait_st(1, 1'b1);
		chk("rx_byte", rx_byte, exp);
		ticks(1);
		cmd_ready <= 1'b1;
		ticks(1);
		cmd_ready <= 1'b0;
		ticks(2);
	endtask
	task automatic brk_op(input logic en, input logic [7:0] op, input logic exp);
		ticks(1);
		bp_enable <= en;
		opcode <= op;
		opcode_valid <= 1'b1;
		ticks(1);
		opcode_valid <= 1'b0;
		ticks(2);
		@(negedge clk_sys);
		chk("debug_mode", debug_mode, exp);
		chk("core_stall", core_stall, exp);
	endtask
	// c: addr miss, expect, ctrl[2:0], read, write, data miss
	task automatic wp(input logic [7:0] c);
		ticks(1);
		wp_ctrl <= c[5:3];
		rf_addr <= wp_addr ^ {11'h000, c[7]};
		rf_data <= wp_data ^ {7'h00, c[0]};
		rf_rd <= c[2];
		rf_wr <= c[1];
		ticks(1);
		rf_rd <= 1'b0;
		rf_wr <= 1'b0;
		ticks(2);
		@(negedge clk_sys);
		chk("watch", debug_mode, {7'h00, c[6]});
		ticks(1);
		debug_exit <= 1'b1;
		ticks(1);
		debug_exit <= 1'b0;
	endtask
	initial begin
		ticks(2);
		@(negedge clk_sys);
		chk("oe_n", dline_oe_n, 1'b1);
		ticks(1);
		rstn <= 1'b1;
		host_u.hold(1'b1, 2);
		host_u.rate();
		chk("locked", baud_locked, 1'b1);
		// fill the receive buffer to its depth, then drain in order
		for (k = 0; k < 16; k++) host_u.send(8'ha0 + 8'(k), 1'b1);
		for (k = 0; k < 16; k++) drain(8'ha0 + 8'(k));
		@(negedge clk_sys);
		chk("rx_valid", rx_valid, 1'b0);
		brk_op(1'b0, 8'h00, 1'b0);
		brk_op(1'b1, 8'h01, 1'b0);
		brk_op(1'b1, 8'h00, 1'b1);
		// host break while in debug mode
		pulse_clr();
		host_u.hold(1'b0, 12);
		chk("break", seen[3:2], 2'h3);
		chk("locked", baud_locked, 1'b0);
		host_u.hold(1'b1, 4);
		chk("locked", baud_locked, 1'b0);
		host_u.rate();
		chk("locked", baud_locked, 1'b1);
		chk("debug_mode", debug_mode, 1'b1);
		ticks(1);
		debug_exit <= 1'b1;
		ticks(1);
		debug_exit <= 1'b0;
		wp(8'h4c);
		wp(8'h0a);
		wp(8'h52);
		wp(8'h5c);
		wp(8'h6c);
		wp(8'h72);
		wp(8'h2d);
		wp(8'h9c);
		// low stop bit, then the device break of forty bit times
		pulse_clr();
		host_u.send(8'h5a, 1'b0);
		chk("frame", {seen[3], seen[1]}, 2'h3);
		chk("oe_n", dline_oe_n, 1'b0);
		chk("dline_out", dline_out, 1'b0);
		wait_st(3, 1'b1);
		// the pull length is latched one edge after the release
		@(negedge clk_sys);
		chk("brk_len", brk_len > 39 * BT && brk_len < 41 * BT, 1'b1);
		chk("locked", baud_locked, 1'b0);
		ticks(1);
		host_u.rate();
		// host pulls a released data bit low during a transmit
		pulse_clr();
		chk("tx_ready", tx_ready, 1'b1);
		tx_byte <= 8'hff;
		tx_valid <= 1'b1;
		ticks(1);
		tx_valid <= 1'b0;
		host_u.hold(1'b1, 4);
		host_u.hold(1'b0, 2);
		host_u.hold(1'b1, 1);
		chk("collide", {seen[3], seen[0]}, 2'h3);
		wait_st(3, 1'b1);
		ticks(1);
		host_u.rate();
		chk("locked", baud_locked, 1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
